// [hdl/nbh_consts.svh]
// timing figures, command codes and counts for the nand bus host
`ifndef NBH_CONSTS_SVH
`define NBH_CONSTS_SVH
`define NBH_CLK_NS 40
`define NBH_FLOOR(ns) ((ns) / `NBH_CLK_NS)
`define NBH_CEIL(ns) (((ns) + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`define NBH_PROG_NS 600000
`define NBH_READ_NS 70000
`define NBH_DBSY_NS 1000
`define NBH_FEAT_NS 1000
`define NBH_OTP_NS 50000
`define NBH_ERASE_NS 3500000
`define NBH_RST_IDLE_NS 5000
`define NBH_RST_RD_NS 10000
`define NBH_RST_PE_NS 500000
`define NBH_ADL_NS 70
`define NBH_WB_NS 100
`define NBH_GAP_CYC 3'(`NBH_CEIL(`NBH_ADL_NS))
`define NBH_WB_CYC 3'(`NBH_CEIL(`NBH_WB_NS) + 3)
`define NBH_RD_CYC 3'h5
`define NBH_NOP_MAX 3'h4
`define NBH_ROW_IDX 3'h2
`define NBH_TW 17
`define NBH_C_RD1 8'h00
`define NBH_C_RD2 8'h30
`define NBH_C_RDI 8'h85
`define NBH_C_RDO1 8'h05
`define NBH_C_RDO2 8'he0
`define NBH_C_ID 8'h90
`define NBH_C_PARM 8'hec
`define NBH_C_UID 8'hed
`define NBH_C_SETF 8'hef
`define NBH_C_GETF 8'hee
`define NBH_C_RST 8'hff
`define NBH_C_PROG 8'h80
`define NBH_C_PCONF 8'h10
`define NBH_C_CACHE 8'h15
`define NBH_C_PLANE 8'h11
`define NBH_C_ERS 8'h60
`define NBH_C_ECONF 8'hd0
`define NBH_C_EPLANE 8'hd1
`define NBH_C_STAT 8'h70
`define NBH_C_ESTAT 8'h78
`endif

// [hdl/nbh_host.sv]
// nand bus host: strobe sequencer, busy watch and write data fifo
`timescale 1ns/1ps
`include "nbh_consts.svh"

module nbh_fifo #(parameter int unsigned W = 8, D = 32, AW = $clog2(D)) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0]  mem [D];      // storage, depth must be a power of two
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;  // words held
  logic          push, pop;
  logic          rdy_q, rdy_d;  // room flag, registered so in_ready leaves a flip-flop
  // pointer and count next values
  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = rdy_q;
    out_valid = cnt_q != '0;
    out_data  = mem[rd_q];
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rdy_d     = cnt_d != (AW+1)'(D);
  end
  // pointers reset, storage does not need to
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= in_data;
  end
endmodule // nbh_fifo

module nbh_host import nbh_pkg::*; #(
  parameter int unsigned PROG_LIMIT   = `NBH_FLOOR(`NBH_PROG_NS),
  parameter int unsigned ERASE_LIMIT  = `NBH_FLOOR(`NBH_ERASE_NS),
  parameter int unsigned RST_PE_LIMIT = `NBH_FLOOR(`NBH_RST_PE_NS)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire nbh_req_type req,
  input  wire logic        req_valid,
  output logic             req_ack,
  input  wire logic [7:0]  wdata,
  input  wire logic        wdata_valid,
  output logic             wdata_ready,
  output logic [7:0]       rdata,
  output logic             rdata_valid,
  input  wire logic        protect_req,
  output nbh_stat_type     stat,
  output nbh_pins_type     pins,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ready_busy_n
);
  nbh_state_type   st_q, st_d;
  nbh_op_type      op_q, op_d;
  nbh_pins_type    pins_d;
  nbh_stat_type    stat_d;
  logic [7:0]      byte_q, byte_d, dout_d, rdata_d;
  logic            oe_d, rvalid_d, ack_d;
  logic [2:0]      cnt_q, cnt_d;          // phase counter
  logic [`NBH_TW-1:0] timer_q, timer_d, limit_q, limit_d;
  logic            wait_q, wait_d;        // busy wait in progress
  logic            pe_q, pe_d, rd_q, rd_d; // class of the pending operation
  logic            smode_q, smode_d;      // last command was a status read
  logic [2:0]      nop_q, nop_d, aidx_q, aidx_d;
  logic [23:0]     row_q, row_d, last_q, last_d;
  logic [2:0]      rb_s_q;                // ready pin synchroniser
  logic            rb_q, rb_d;            // filtered ready level
  logic [7:0]      dq_s1_q, dq_s2_q, dq_s3_q, dq_lvl_q, dq_lvl_d;
  logic            take, fifo_valid, fifo_pop;
  logic [7:0]      fifo_data;

  // write data is buffered so a page can stream in while a busy wait runs
  nbh_fifo #(.W(8), .D(32)) u_fifo (
    .clk(clk), .rst_n(rst_n), .in_valid(wdata_valid), .in_data(wdata), .in_ready(wdata_ready),
    .out_valid(fifo_valid), .out_data(fifo_data), .out_ready(fifo_pop));

  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      `NBH_C_RD1, `NBH_C_RD2, `NBH_C_RDI, `NBH_C_RDO1, `NBH_C_RDO2, `NBH_C_ID, `NBH_C_PARM,
      `NBH_C_UID, `NBH_C_SETF, `NBH_C_GETF, `NBH_C_RST, `NBH_C_PROG, `NBH_C_PCONF, `NBH_C_CACHE,
      `NBH_C_PLANE, `NBH_C_ERS, `NBH_C_ECONF, `NBH_C_EPLANE, `NBH_C_STAT, `NBH_C_ESTAT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic cmd_write(input logic [7:0] c);
    case (c)
      `NBH_C_PROG, `NBH_C_RDI, `NBH_C_PCONF, `NBH_C_CACHE, `NBH_C_PLANE, `NBH_C_ERS,
      `NBH_C_ECONF, `NBH_C_EPLANE, `NBH_C_SETF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // busy bound for a command; zero means no busy follows it
  function automatic logic [`NBH_TW-1:0] cmd_limit(input logic [7:0] c, input logic rd, input logic pe);
    case (c)
      `NBH_C_PCONF, `NBH_C_CACHE: return `NBH_TW'(PROG_LIMIT);
      `NBH_C_PLANE, `NBH_C_EPLANE: return `NBH_TW'(`NBH_FLOOR(`NBH_DBSY_NS));
      `NBH_C_GETF: return `NBH_TW'(`NBH_FLOOR(`NBH_FEAT_NS));
      `NBH_C_SETF: return `NBH_TW'(`NBH_FLOOR(`NBH_OTP_NS));
      `NBH_C_RD2: return `NBH_TW'(`NBH_FLOOR(`NBH_READ_NS));
      `NBH_C_ECONF: return `NBH_TW'(ERASE_LIMIT);
      `NBH_C_RST: return pe ? `NBH_TW'(RST_PE_LIMIT) :
                         rd ? `NBH_TW'(`NBH_FLOOR(`NBH_RST_RD_NS)) : `NBH_TW'(`NBH_FLOOR(`NBH_RST_IDLE_NS));
      default: return '0;
    endcase
  endfunction

  // request admission: while busy only status, reset or status data may pass
  always_comb begin
    take = req_valid && !req_ack && !(req.op == OP_DIN && !fifo_valid) &&
           (st_q == ST_IDLE || (st_q == ST_BUSY && !rb_q && timer_q < limit_q &&
            ((req.op == OP_CMD && (req.data == `NBH_C_STAT || req.data == `NBH_C_ESTAT ||
              req.data == `NBH_C_RST)) || (req.op == OP_DOUT && smode_q))));
  end

  // sequencer next values
  always_comb begin
    st_d = st_q; op_d = op_q; byte_d = byte_q; cnt_d = cnt_q; wait_d = wait_q;
    limit_d = limit_q; pe_d = pe_q; rd_d = rd_q; smode_d = smode_q; nop_d = nop_q;
    aidx_d = aidx_q; row_d = row_q; last_d = last_q; rdata_d = rdata;
    pins_d = pins; dout_d = dq_out; oe_d = dq_oe; rvalid_d = 1'b0; ack_d = 1'b0;
    stat_d = '{busy: wait_q, timeout: 1'b0, refused: 1'b0};
    fifo_pop = 1'b0;
    timer_d = wait_q ? timer_q + 1'b1 : '0;
    case (st_q)
      ST_IDLE, ST_BUSY: begin
        if (st_q == ST_BUSY && rb_q) begin
          wait_d = 1'b0; pe_d = 1'b0; rd_d = 1'b0; st_d = ST_IDLE;
        end else if (st_q == ST_BUSY && timer_q >= limit_q) begin
          wait_d = 1'b0; pe_d = 1'b0; rd_d = 1'b0; st_d = ST_IDLE;
          stat_d.timeout = 1'b1;
        end else if (take) begin
          ack_d = 1'b1;
          if (req.op == OP_CMD && (!cmd_known(req.data) || (cmd_write(req.data) && protect_req))) begin
            stat_d.refused = 1'b1;
          end else if (req.op == OP_CMD && req.data == `NBH_C_PCONF && row_q == last_q && nop_q == `NBH_NOP_MAX) begin
            stat_d.refused = 1'b1;
          end else begin
            op_d = req.op; byte_d = req.data; st_d = ST_SETUP;
            if (req.op == OP_DIN) begin
              byte_d = fifo_data; fifo_pop = 1'b1;
            end
            if (req.op == OP_CMD) begin
              aidx_d = '0;
              smode_d = req.data == `NBH_C_STAT || req.data == `NBH_C_ESTAT;
              if (req.data == `NBH_C_ECONF) nop_d = '0;
              if (req.data == `NBH_C_PCONF) begin
                last_d = row_q;
                nop_d = row_q == last_q ? nop_q + 3'h1 : 3'h1;
              end
            end
            if (req.op == OP_ADDR) begin
              aidx_d = aidx_q + 3'h1;
              if (aidx_q >= `NBH_ROW_IDX) row_d = {row_q[15:0], req.data};
            end
          end
        end
      end
      ST_SETUP: begin
        pins_d.ce_n = 1'b0;
        pins_d.cle = op_q == OP_CMD;
        pins_d.ale = op_q == OP_ADDR;
        oe_d = op_q != OP_DOUT;
        dout_d = byte_q;
        pins_d.we_n = op_q == OP_DOUT;
        pins_d.read_strobe_n = op_q != OP_DOUT;
        cnt_d = '0; st_d = ST_STROBE;
      end
      ST_STROBE: begin
        cnt_d = cnt_q + 3'h1;
        if (op_q != OP_DOUT) begin
          pins_d.we_n = 1'b1; st_d = ST_HOLD;
        end else if (cnt_q == `NBH_RD_CYC) begin
          // the bus is re-sampled after three stages, so the strobe is stretched
          rdata_d = dq_lvl_q; rvalid_d = 1'b1;
          pins_d.read_strobe_n = 1'b1; st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        pins_d.cle = 1'b0; pins_d.ale = 1'b0; oe_d = 1'b0;
        cnt_d = '0; st_d = ST_GAP;
      end
      ST_GAP: begin
        // spacing covers write-to-read turnaround and address-to-data delay
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `NBH_GAP_CYC - 3'h1) begin
          cnt_d = '0;
          st_d = wait_q ? ST_BUSY : ST_IDLE;
          if (op_q == OP_CMD && cmd_limit(byte_q, rd_q, pe_q) != '0) begin
            limit_d = cmd_limit(byte_q, rd_q, pe_q);
            wait_d = 1'b1; timer_d = '0; st_d = ST_WB;
            if (byte_q != `NBH_C_RST) begin
              pe_d = cmd_write(byte_q); rd_d = !cmd_write(byte_q);
            end
          end
        end
      end
      ST_WB: begin
        // ready may drop late and the synchroniser lags: wait before looking
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `NBH_WB_CYC) st_d = ST_BUSY;
      end
      default: st_d = ST_IDLE;
    endcase
    if (st_d == ST_IDLE || st_d == ST_WB || st_d == ST_BUSY) pins_d.ce_n = 1'b1;
    pins_d.wp_n = (wait_d && pe_d) ? 1'b1 : !protect_req;
    stat_d.busy = wait_d;
  end

  // filtered levels change only when the second and third stages agree
  always_comb begin
    rb_d = rb_s_q[1] == rb_s_q[2] ? rb_s_q[2] : rb_q;
    dq_lvl_d = dq_s2_q == dq_s3_q ? dq_s3_q : dq_lvl_q;
  end

  // state registers; pins idle deselected with strobes high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; op_q <= OP_CMD; byte_q <= 8'h00; cnt_q <= 3'h0;
      timer_q <= '0; limit_q <= '0; wait_q <= 1'b0; pe_q <= 1'b0; rd_q <= 1'b0;
      smode_q <= 1'b0; nop_q <= 3'h0; aidx_q <= 3'h0; row_q <= 24'h000000; last_q <= 24'h000000;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1, wp_n: 1'b0};
      dq_out <= 8'h00; dq_oe <= 1'b0; rdata <= 8'h00; rdata_valid <= 1'b0; req_ack <= 1'b0;
      stat <= '0; rb_s_q <= 3'h0; rb_q <= 1'b0;
      dq_s1_q <= 8'h00; dq_s2_q <= 8'h00; dq_s3_q <= 8'h00; dq_lvl_q <= 8'h00;
    end else begin
      st_q <= st_d; op_q <= op_d; byte_q <= byte_d; cnt_q <= cnt_d;
      timer_q <= timer_d; limit_q <= limit_d; wait_q <= wait_d; pe_q <= pe_d; rd_q <= rd_d;
      smode_q <= smode_d; nop_q <= nop_d; aidx_q <= aidx_d; row_q <= row_d; last_q <= last_d;
      pins <= pins_d; dq_out <= dout_d; dq_oe <= oe_d; rdata <= rdata_d;
      rdata_valid <= rvalid_d; req_ack <= ack_d; stat <= stat_d;
      rb_s_q <= {rb_s_q[1:0], ready_busy_n}; rb_q <= rb_d;
      dq_s1_q <= dq_in; dq_s2_q <= dq_s1_q; dq_s3_q <= dq_s2_q; dq_lvl_q <= dq_lvl_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait_over;
    st_q == ST_BUSY && wait_q && !rb_q && timer_q >= limit_q;
  endsequence
  sequence s_timeout_seen;
    stat.timeout && !stat.busy && st_q == ST_IDLE;
  endsequence
  a_addr_cycle_lines: assert property ($fell(pins.we_n) && pins.ale |-> !pins.cle && pins.read_strobe_n && !pins.ce_n)
    else $error("address strobe with wrong lines");
  a_cmd_cycle_lines: assert property ($fell(pins.we_n) && pins.cle |-> !pins.ale && pins.read_strobe_n && !pins.ce_n)
    else $error("command strobe with wrong lines");
  a_data_in_lines: assert property ($fell(pins.we_n) && !pins.cle && !pins.ale |-> pins.wp_n && dq_oe)
    else $error("data in strobe without drive or write enable");
  a_read_strobe_lines: assert property ($fell(pins.read_strobe_n) |-> pins.we_n && !pins.cle && !pins.ale && !dq_oe)
    else $error("read strobe with wrong lines");
  a_busy_wp_high: assert property (wait_q && pe_q |-> pins.wp_n)
    else $error("write protect low during program or erase busy");
  a_addr_data_gap: assert property ($fell(pins.we_n) && pins.ale |=> pins.we_n [*3])
    else $error("strobe too soon after address cycle");
  a_undef_refused: assert property (take && req.op == OP_CMD && !cmd_known(req.data) |=> stat.refused && st_q != ST_SETUP)
    else $error("undefined command not refused");
  a_busy_bound: assert property (s_wait_over |=> s_timeout_seen)
    else $error("busy wait not ended at its bound");
  a_ready_ends: assert property (st_q == ST_BUSY && wait_q && rb_q |=> !wait_q ##1 !stat.busy)
    else $error("ready did not end the wait");
  a_status_busy: assert property (take && st_q == ST_BUSY && req.op == OP_CMD && req.data == `NBH_C_STAT |=> st_q == ST_SETUP ##1 pins.cle)
    else $error("status read not issued while busy");
endmodule // nbh_host

// [hdl/nbh_pkg.sv]
// types shared by the nand bus host
package nbh_pkg;
  typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_DIN, OP_DOUT} nbh_op_type;
  typedef struct packed {
    nbh_op_type  op;    // kind of bus cycle
    logic [7:0]  data;  // command or address byte
  } nbh_req_type;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } nbh_pins_type;
  typedef struct packed {
    logic busy;     // waiting on the device
    logic timeout;  // busy outlasted its bound
    logic refused;  // request dropped
  } nbh_stat_type;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP, ST_WB, ST_BUSY} nbh_state_type;
endpackage

// [testbench/nbh_dev_model.sv]
// behavioural nand device answering the host's strobes
`timescale 1ns/1ps
module nbh_dev_model import nbh_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire nbh_pins_type pins,
  input  wire logic [7:0]   dq_out,
  input  wire logic         dq_oe,
  output logic [7:0]        dq_in,
  output logic              ready_busy_n,
  input  wire logic         slow,
  output logic [15:0]       n_cmd,
  output logic [39:0]       addr_log,
  output logic [31:0]       din_log,
  output logic [7:0]        wp_err
);
  logic        we_q;   // previous write strobe
  logic        rs_q;   // previous read strobe
  logic        stat_q; // status mode after 70h/78h
  logic        pe_q;   // program or erase in progress
  logic [10:0] bcnt;   // busy cycles left
  logic [7:0]  val;    // byte shown while read strobe is low
  logic [7:0]  k;      // read index since array read
  // pin has a pull-up, so ready simply follows the counter
  assign ready_busy_n = (bcnt == 11'h000);
  // a released bus shows the inverse of the last byte, never a stale copy
  assign dq_in = pins.read_strobe_n ? ~val : val;
  // bus decode and busy timing; slow stretches program beyond its bound
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {we_q, rs_q, stat_q, pe_q} <= 4'hc;
      {bcnt, val, k, n_cmd, wp_err} <= '0;
      {addr_log, din_log} <= '0;
    end else begin
      we_q <= pins.we_n;
      rs_q <= pins.read_strobe_n;
      if (bcnt != 11'h000) bcnt <= bcnt - 11'h001;
      else pe_q <= 1'b0;
      if (pe_q && !pins.wp_n) wp_err <= wp_err + 8'h01;
      // latch on the rising write strobe
      if (!we_q && pins.we_n && !pins.ce_n && pins.read_strobe_n) begin
        if (pins.cle && !pins.ale) begin
          n_cmd <= n_cmd + 16'h0001;
          stat_q <= (dq_out == 8'h70) || (dq_out == 8'h78);
          case (dq_out)
            8'h10, 8'h15: {bcnt, pe_q} <= {(slow ? 11'h190 : 11'h014), 1'b1};
            8'h11, 8'hd1: {bcnt, pe_q} <= {11'h00a, 1'b1};
            8'hd0: {bcnt, pe_q} <= {11'h028, 1'b1};
            8'hee, 8'hef: bcnt <= 11'h00a;
            8'h30: {bcnt, k} <= {11'h01e, 8'h00};
            8'hff: {bcnt, pe_q} <= {11'h00a, 1'b0};
            default: ;
          endcase
        end else if (pins.ale && !pins.cle) addr_log <= {addr_log[31:0], dq_out};
        else if (!pins.ale && !pins.cle && pins.wp_n) din_log <= {din_log[23:0], dq_out};
      end
      // new output byte on each falling read strobe
      if (rs_q && !pins.read_strobe_n && !pins.ce_n && pins.we_n) begin
        val <= stat_q ? (ready_busy_n ? 8'he0 : 8'ha0) : (8'ha5 ^ k);
        k <= k + 8'h01;
      end
    end
  end
endmodule // nbh_dev_model

// [testbench/nbh_host_test.sv]
// self-checking bench for the nand bus host
`timescale 1ns/1ps
module nbh_host_test import nbh_pkg::*; ;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  nbh_req_type  req = '0;
  logic         req_valid = 1'b0;
  logic         protect_req = 1'b0;
  logic         wdata_valid = 1'b0;
  logic         slow = 1'b0;
  logic [7:0]   wdata = 8'h00;
  logic         req_ack, wdata_ready, rdata_valid, dq_oe, ready_busy_n;
  logic [7:0]   rdata, dq_out, dq_in, wp_err, rbyte;
  nbh_stat_type stat;
  nbh_pins_type pins;
  logic [15:0]  n_cmd;
  logic [39:0]  addr_log;
  logic [31:0]  din_log;
  logic [23:0]  row;
  logic [7:0]   q [32];    // bytes pushed into the fifo
  logic [7:0]   wcode [9] = '{8'h80, 8'h85, 8'h10, 8'h11, 8'h15, 8'h60, 8'hd0, 8'hd1, 8'hef};
  int           n_mismatch = 0;
  int           samples_checked = 0;
  int           n_ref = 0, n_tmo = 0, cyc = 0, t;

  // short limits keep the run brief; the model's slow busy outlasts PROG_LIMIT
  nbh_host #(.PROG_LIMIT(200), .ERASE_LIMIT(300), .RST_PE_LIMIT(150)) nbh_host_i (
    .clk(clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ack(req_ack),
    .wdata(wdata), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .rdata(rdata),
    .rdata_valid(rdata_valid), .protect_req(protect_req), .stat(stat), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  nbh_dev_model nbh_dev_model_i (
    .clk(clk), .rst_n(rst_n), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n), .slow(slow), .n_cmd(n_cmd), .addr_log(addr_log),
    .din_log(din_log), .wp_err(wp_err));

  always #20 clk = ~clk;

  // pulse counters and the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stat.refused === 1'b1) n_ref <= n_ref + 1;
    if (stat.timeout === 1'b1) n_tmo <= n_tmo + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_read(input int i);
    return 8'ha5 ^ 8'(i);
  endfunction

  // one request held until acknowledged; a read also waits for its byte
  task automatic issue(input nbh_op_type op, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{op, d};
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (req_ack !== 1'b1 && n < 3000);
    check(req_ack, 1'b1, "request ack");
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    while (op == OP_DOUT && rdata_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    rbyte = rdata;
  endtask

  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    wdata <= b;
    wdata_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (wdata_ready !== 1'b1 && n < 50);
    check(wdata_ready, 1'b1, "fifo accepts");
    @(posedge clk);
    wdata_valid <= 1'b0;
  endtask

  // device busy must be seen, then must end within lim cycles
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    repeat (10) @(negedge clk);
    check(stat.busy, 1'b1, "busy seen");
    while (stat.busy !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(n < lim, 1'b1, "busy end");
    check(wp_err, 8'h00, "wp during busy");
  endtask

  task automatic prog_hdr(input logic [7:0] c, input logic [23:0] r);
    issue(OP_CMD, c);
    issue(OP_ADDR, 8'h00);
    issue(OP_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) issue(OP_ADDR, r[8*i +: 8]);
  endtask

  // a refused command gives a pulse and leaves the bus untouched
  task automatic refuse(input logic [7:0] c);
    int r;
    logic [15:0] m;
    r = n_ref;
    m = n_cmd;
    issue(OP_CMD, c);
    @(negedge clk);
    check(n_ref, r + 1, "refused");
    check(n_cmd, m, "no bus cycle");
  endtask

  initial begin
    void'($urandom(32'h960d));
    foreach (q[i]) q[i] = 8'($urandom);
    row = 24'($urandom);
    repeat (4) @(posedge clk);
    check(pins, 6'h26, "reset pins");
    rst_n <= 1'b1;
    // program: fifo filled to refusal, drained in order
    prog_hdr(8'h80, row);
    // the model latches one edge after the rising write strobe, three edges after the ack cycle
    repeat (3) @(negedge clk);
    check(addr_log, {16'h0000, row[7:0], row[15:8], row[23:16]}, "address");
    for (int i = 0; i < 32; i++) push(q[i]);
    @(negedge clk);
    check(wdata_ready, 1'b0, "fifo full");
    for (int i = 0; i < 32; i++) issue(OP_DIN, 8'h00);
    repeat (3) @(negedge clk);
    check(din_log, {q[28], q[29], q[30], q[31]}, "data in");
    issue(OP_CMD, 8'h10);
    wait_idle(300);
    // array read and data out
    prog_hdr(8'h00, row);
    issue(OP_CMD, 8'h30);
    wait_idle(300);
    for (int i = 0; i < 4; i++) begin
      issue(OP_DOUT, 8'h00);
      check(rbyte, exp_read(i), "read byte");
    end
    prog_hdr(8'h80, row);
    issue(OP_CMD, 8'h11);
    wait_idle(60);
    prog_hdr(8'h80, row);
    issue(OP_CMD, 8'h15);
    wait_idle(300);
    issue(OP_CMD, 8'hef);
    wait_idle(1400);
    issue(OP_CMD, 8'hee);
    wait_idle(60);
    // slow program: status read while busy, then timeout and reset
    slow <= 1'b1;
    t = n_tmo;
    prog_hdr(8'h80, row);
    issue(OP_CMD, 8'h10);
    repeat (40) @(posedge clk);
    issue(OP_CMD, 8'h70);
    issue(OP_DOUT, 8'h00);
    check(rbyte, 8'ha0, "status busy");
    wait_idle(400);
    // the timeout pulse is counted at the edge after busy drops
    @(negedge clk);
    check(n_tmo, t + 1, "timeout");
    slow <= 1'b0;
    issue(OP_CMD, 8'hff);
    wait_idle(300);
    issue(OP_CMD, 8'h78);
    issue(OP_DOUT, 8'h00);
    check(rbyte, 8'he0, "status ready");
    // write protect refuses every write-type command
    @(posedge clk);
    protect_req <= 1'b1;
    repeat (3) @(negedge clk);
    check(pins.wp_n, 1'b0, "wp low");
    foreach (wcode[i]) refuse(wcode[i]);
    @(posedge clk);
    protect_req <= 1'b0;
    refuse(8'h01);
    refuse(8'hfe);
    // partial program count, cleared by erase
    row = 24'($urandom);
    for (int i = 0; i < 4; i++) begin
      prog_hdr(8'h80, row);
      issue(OP_CMD, 8'h10);
      wait_idle(300);
    end
    prog_hdr(8'h80, row);
    refuse(8'h10);
    issue(OP_CMD, 8'h60);
    for (int i = 0; i < 3; i++) issue(OP_ADDR, row[8*i +: 8]);
    issue(OP_CMD, 8'hd0);
    wait_idle(400);
    prog_hdr(8'h80, row);
    issue(OP_CMD, 8'h10);
    wait_idle(300);
    test_done;
  end
endmodule // nbh_host_test
